// ===== src/slx_pkg.sv
// Constants for the serial lane crossbar.
//
// Behaviour
// - A 3-bit source select of value N routes physical input N to its lane.
// - Logical lane 2 select sits in bits 2:0 at 0x309, read-write, reset 2.
// - Logical lane 5 select sits in bits 5:3 at 0x30A, read-write, reset 5.
// - Logical lane 4 select sits in bits 2:0 at 0x30A, read-write, reset 4.
// - Logical lane 7 select sits in bits 5:3 at 0x30B, read-write, reset 7.
// - Logical lane 6 select sits in bits 2:0 at 0x30B, read-write, reset 6.
package slx_pkg;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int PHYS_LANES = 8;
    localparam int OUT_LANES = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int SEL_W = 3;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_SEL_2_3 = 12'h309;
    localparam logic [11:0] OFS_SEL_4_5 = 12'h30A;
    localparam logic [11:0] OFS_SEL_6_7 = 12'h30B;
    localparam int LO_FIELD_LSB = 0;
    localparam int HI_FIELD_LSB = 3;

    // select reset values, output slot k holds lanes 2,4,5,6,7
    localparam logic [2:0] RST_LANE2 = 3'h2;
    localparam logic [2:0] RST_LANE4 = 3'h4;
    localparam logic [2:0] RST_LANE5 = 3'h5;
    localparam logic [2:0] RST_LANE6 = 3'h6;
    localparam logic [2:0] RST_LANE7 = 3'h7;
    localparam logic [14:0] RST_SELS =
        {RST_LANE7, RST_LANE6, RST_LANE5, RST_LANE4, RST_LANE2};

endpackage

// ===== src/slx_serial_lane_crossbar.sv
// Lane FIFO and the crossbar top with its select registers.

// ------------------------------------------------------------
// slx_fifo: first-word-fall-through buffer
// ------------------------------------------------------------
module slx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop;

    // extra pointer bit tells full from empty
    assign in_ready = (wr_ptr[PW] == rd_ptr[PW]) ||
                      (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]);
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data = mem[rd_ptr[PW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer advance
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage has no reset, only written words are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[PW-1:0]] <= in_data;
        end
    end
endmodule

// ------------------------------------------------------------
// slx_serial_lane_crossbar: top
// ------------------------------------------------------------
module slx_serial_lane_crossbar (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] phys_valid,
    output logic [7:0] phys_ready,
    input wire logic [255:0] phys_data,
    output logic [4:0] lane_valid,
    input wire logic [4:0] lane_ready,
    output logic [159:0] lane_data
);
    localparam int W = slx_pkg::DATA_W;
    localparam int NO = slx_pkg::OUT_LANES;
    localparam int NP = slx_pkg::PHYS_LANES;

    logic rst_meta_n, rst_sync_n;
    logic [14:0] sel, next_sel;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic [NO-1:0] fifo_in_valid, fifo_in_ready;
    logic [NO*W-1:0] fifo_in_data;

    // ------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // select registers
    // ------------------------------------------------------------
    // writes touch only the addressed fields; bits 7:6 are not stored
    always_comb begin
        next_sel = sel;
        next_rdata = 8'h00;
        next_rvalid = reg_re;
        if (reg_we && reg_addr == slx_pkg::OFS_SEL_2_3) begin
            next_sel[2:0] = reg_wdata[2:0];
        end else if (reg_we && reg_addr == slx_pkg::OFS_SEL_4_5) begin
            next_sel[5:3] = reg_wdata[2:0];
            next_sel[8:6] = reg_wdata[5:3];
        end else if (reg_we && reg_addr == slx_pkg::OFS_SEL_6_7) begin
            next_sel[11:9] = reg_wdata[2:0];
            next_sel[14:12] = reg_wdata[5:3];
        end
        // lane 3 lives elsewhere, so its field reads zero here
        if (reg_addr == slx_pkg::OFS_SEL_2_3) begin
            next_rdata = {5'h00, sel[2:0]};
        end else if (reg_addr == slx_pkg::OFS_SEL_4_5) begin
            next_rdata = {2'h0, sel[8:6], sel[5:3]};
        end else if (reg_addr == slx_pkg::OFS_SEL_6_7) begin
            next_rdata = {2'h0, sel[14:12], sel[11:9]};
        end
        if (!reg_re) begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sel <= slx_pkg::RST_SELS;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            sel <= next_sel;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // ------------------------------------------------------------
    // crossbar and back-pressure
    // ------------------------------------------------------------
    // each slot muxes with its own select only, so a change moves one lane
    always_comb begin
        for (int k = 0; k < NO; k++) begin
            fifo_in_valid[k] = phys_valid[sel[k*3 +: 3]];
            fifo_in_data[k*W +: W] = phys_data[sel[k*3 +: 3]*W +: W];
        end
        // a shared input waits for every lane that takes it
        for (int n = 0; n < NP; n++) begin
            phys_ready[n] = 1'b1;
            for (int k = 0; k < NO; k++) begin
                if (sel[k*3 +: 3] == n[2:0]) begin
                    phys_ready[n] = phys_ready[n] & fifo_in_ready[k];
                end
            end
        end
    end

    // one buffer per logical lane
    for (genvar k = 0; k < NO; k++) begin : g_lane
        slx_fifo #(
            .WIDTH(W),
            .DEPTH(slx_pkg::FIFO_DEPTH)
        ) u_fifo (
            .core_clk(core_clk),
            .rst_n(rst_sync_n),
            .in_valid(fifo_in_valid[k] && phys_ready[sel[k*3 +: 3]]),
            .in_ready(fifo_in_ready[k]),
            .in_data(fifo_in_data[k*W +: W]),
            .out_valid(lane_valid[k]),
            .out_ready(lane_ready[k]),
            .out_data(lane_data[k*W +: W])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // register steps as named sequences, one idle cycle before readback
    sequence seq_wr_4_5;
        reg_we && reg_addr == slx_pkg::OFS_SEL_4_5;
    endsequence
    sequence seq_wr_6_7;
        reg_we && reg_addr == slx_pkg::OFS_SEL_6_7;
    endsequence
    sequence seq_rd_4_5;
        reg_re && reg_addr == slx_pkg::OFS_SEL_4_5 && !reg_we;
    endsequence

    AST_ROUTE: assert property (@(posedge core_clk)
        disable iff (!rst_sync_n)
        !lane_valid[0] && phys_valid[sel[2:0]] && phys_ready[sel[2:0]]
        |=> lane_valid[0] && lane_data[W-1:0] == $past(fifo_in_data[W-1:0]))
        else $error("lane 2 missed the word of its selected input");
    AST_LANE2_RST: assert property (@(posedge core_clk)
        $rose(rst_sync_n) |-> sel[2:0] == 3'h2)
        else $error("lane 2 select reset wrong");
    AST_LANE5_WR: assert property (@(posedge core_clk)
        disable iff (!rst_sync_n)
        seq_wr_4_5 ##1 !reg_we ##1 seq_rd_4_5
        |=> reg_rdata[5:3] == $past(reg_wdata[5:3], 3))
        else $error("lane 5 select readback wrong");
    AST_LANE4_WR: assert property (@(posedge core_clk)
        disable iff (!rst_sync_n)
        seq_wr_4_5 |=> sel[5:3] == $past(reg_wdata[2:0]))
        else $error("lane 4 select not written");
    AST_LANE7_WR: assert property (@(posedge core_clk)
        disable iff (!rst_sync_n)
        seq_wr_6_7 |=> sel[14:12] == $past(reg_wdata[5:3]))
        else $error("lane 7 select not written");
    AST_LANE6_WR: assert property (@(posedge core_clk)
        disable iff (!rst_sync_n)
        seq_wr_6_7 |=> sel[11:9] == $past(reg_wdata[2:0]))
        else $error("lane 6 select not written");
    AST_LANE6_KEEP: assert property (@(posedge core_clk)
        disable iff (!rst_sync_n)
        !(reg_we && reg_addr == slx_pkg::OFS_SEL_6_7) |=> $stable(sel[11:9]))
        else $error("lane 6 select changed without write");
    AST_RSVD_ZERO: assert property (@(posedge core_clk)
        disable iff (!rst_sync_n)
        reg_rvalid |-> reg_rdata[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
endmodule

// ===== testbench/slx_link_tx.sv
// Behavioural model of the serial link transmitter feeding the crossbar.
module slx_link_tx (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [2:0] src,
    input wire logic [31:0] word,
    input wire logic [7:0] phys_ready,
    output logic [7:0] phys_valid,
    output logic [255:0] phys_data,
    output logic taken
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        phys_valid = 8'h00;
        phys_data = '0;
        taken = 1'b0;
    end
    // one word in flight, held until ready; a released word is inverted
    // so a stale value can never pass for fresh data
    always @(posedge core_clk) begin
        taken <= |(phys_valid & phys_ready);
        if (|(phys_valid & phys_ready)) begin
            phys_valid <= 8'h00;
            phys_data <= ~phys_data;
        end else if (go && phys_valid == 8'h00) begin
            phys_valid[src] <= 1'b1;
            phys_data[src*32 +: 32] <= word;
        end
    end
endmodule

// ===== testbench/slx_serial_lane_crossbar_bench.sv
// Self-checking bench for the serial lane crossbar.
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module slx_serial_lane_crossbar_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic go = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [4:0] lane_ready = 5'h1F;
    logic [2:0] src = 3'h0;
    logic [31:0] word = 32'h0;
    logic taken, reg_rvalid;
    logic [7:0] reg_rdata, phys_valid, phys_ready;
    logic [255:0] phys_data;
    logic [4:0] lane_valid;
    logic [159:0] lane_data;
    int n_mismatch = 0;
    int samples_checked = 0;
    // 8 ns period
    always #4 core_clk = ~core_clk;
    slx_serial_lane_crossbar DUT (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .phys_valid(phys_valid),
        .phys_ready(phys_ready), .phys_data(phys_data),
        .lane_valid(lane_valid), .lane_ready(lane_ready),
        .lane_data(lane_data));
    slx_link_tx tx (.core_clk(core_clk), .go(go), .src(src), .word(word),
        .phys_ready(phys_ready), .phys_valid(phys_valid),
        .phys_data(phys_data), .taken(taken));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge core_clk);
        reg_we <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, reg_rvalid)
        `CHK("rdata", e, reg_rdata)
        @(posedge core_clk);
    endtask
    // returns off the edge, just after the word was taken
    task send(input logic [2:0] n, input logic [31:0] w);
        int i;
        src <= n;
        word <= w;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if (taken === 1'b1) return;
        end
        n_mismatch++;
        $display("[ERR] send timeout on input %0d", n);
        conclude();
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(12'h309, 8'h02);
        rd(12'h30A, 8'h2C);
        rd(12'h30B, 8'h3E);
        rd(12'h30C, 8'h00);
    endtask
    task t_rw;
        wr(12'h30A, 8'hFF);
        rd(12'h30A, 8'h3F);
        wr(12'h30B, 8'hC9);
        rd(12'h30B, 8'h09);
        wr(12'h309, 8'hFF);
        rd(12'h309, 8'h07);
        wr(12'h30B, 8'h3E);
        wr(12'h309, 8'h02);
    endtask
    // every code on lane 4; the other lanes keep their own inputs
    task t_route;
        logic [2:0] n;
        logic [4:0] exp_v;
        logic [31:0] exp_w;
        int slot;
        for (int k = 0; k < 8; k++) begin
            n = k[2:0];
            exp_v = {n == 3'h7, n == 3'h6, n == 3'h5, 1'b1, n == 3'h2};
            exp_w = {29'h1A2B3C4, n};
            wr(12'h30A, {2'h0, 3'h5, n});
            send(n, exp_w);
            `CHK("valid", exp_v, lane_valid)
            `CHK("lane4", exp_w, lane_data[32 +: 32])
            // the lane that owns input n by default takes the word as well
            if (n == 3'h2 || n > 3'h4) begin
                slot = (n == 3'h2) ? 0 : int'(n) - 3;
                `CHK("own lane", exp_w, lane_data[slot*32 +: 32])
            end
            @(posedge core_clk);
        end
        wr(12'h30A, 8'h2C);
    endtask
    // lane 2 stalls until its buffer refuses, then drains in order
    task t_fill;
        lane_ready <= 5'h1E;
        for (int i = 0; i < 16; i++) begin
            send(3'h2, 32'h0F00 + i);
            @(posedge core_clk);
        end
        src <= 3'h2;
        word <= 32'h0F10;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("refused", 1'b0, phys_ready[2])
        @(posedge core_clk);
        lane_ready <= 5'h1F;
        for (int i = 0; i < 17; i++) begin
            #1;
            `CHK("drain", 32'h0F00 + i, lane_data[31:0])
            @(posedge core_clk);
        end
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_rw();
        t_route();
        t_fill();
        conclude();
    end
endmodule
